// [common/fmm_regs.svh]
`ifndef FMM_REGS_SVH
`define FMM_REGS_SVH
// flash geometry
`define FMM_BLK_COUNT      12
`define FMM_BLK_BITS       13
`define FMM_FLASH_BITS     17
`define FMM_FLASH_BYTES    98304
// universal map windows (24-bit addresses)
`define FMM_FLASH_BASE     24'h800000
`define FMM_FLASH_LAST     24'h817fff
`define FMM_LDR_BASE       24'h800000
`define FMM_LDR_LAST       24'h800fff
`define FMM_DATA_BASE      24'h7f0000
`define FMM_DATA_LAST      24'h7f007f
`define FMM_INDIRECT_RAM_LAST     24'h7f00ff
`define FMM_EXTENDED_RAM_LAST     24'h7f04ff
`define FMM_XRAM_BASE      24'h000000
`define FMM_XRAM_LAST      24'h0002ff
`define FMM_CODE_TOP       24'h7fffff
// aux function register one
`define FMM_AUX1_ADDR      8'ha2
`define FMM_AUX1_RESET     8'h00
`define FMM_AUX1_LDR_BIT   5
`define FMM_AUX1_WMASK     8'h29
`define FMM_AUX1_ZERO_BIT  2
`define FMM_AUX1_ONE_MASK  8'h00
// timing, in nanoseconds
`define FMM_CLK_NS         8
`define FMM_PROG_NS        20000
`define FMM_BLK_ERASE_NS   1000000000
`define FMM_CHIP_ERASE_NS  1000000000
`define FMM_ERASED_BYTE    8'hff
`endif

// [common/fmm_pkg.sv]
package fmm_pkg;
  // flash command codes
  typedef enum logic [1:0] {
    FMM_CMD_PROG,
    FMM_CMD_BLK_ERASE,
    FMM_CMD_CHIP_ERASE,
    FMM_CMD_NONE
  } fmm_cmd_t;

  // flash request from the core
  typedef struct packed {
    fmm_cmd_t    cmd;
    logic [16:0] addr;
    logic [7:0]  data;
  } fmm_flash_req_t;

  // data access target
  typedef enum logic [2:0] {
    FMM_TGT_EXT,
    FMM_TGT_IRAM,
    FMM_TGT_SFR,
    FMM_TGT_XRAM,
    FMM_TGT_FLASH,
    FMM_TGT_LOADER
  } fmm_tgt_t;

  // data access request kinds
  typedef struct packed {
    logic        direct;
    logic        indirect;
    logic        uptr;
    logic        xmove;
    logic [23:0] addr;
  } fmm_dacc_t;
endpackage

// [hdl/fmm_flash_timer.sv]
`timescale 1ns/1ps
`include "fmm_regs.svh"
// ----------------------------------------
// program/erase duration counter
// ----------------------------------------
module fmm_flash_timer #(
  parameter int unsigned WIDTH = 28
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             start_i,   // one-cycle load pulse
  input  wire logic [WIDTH-1:0] cycles_i,  // duration in cycles
  output logic                  busy_o,    // counting
  output logic                  done_o     // one-cycle finish pulse
);
  logic [WIDTH-1:0] count_reg;  // remaining cycles

  initial begin
    if (WIDTH < 2) $error("timer width too small");
  end

  // count down; reload wins over an ongoing count
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_reg <= '0;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
    end else if (start_i) begin
      count_reg <= cycles_i;
      busy_o    <= 1'b1;
      done_o    <= 1'b0;
    end else if (busy_o) begin
      count_reg <= count_reg - WIDTH'(1);
      done_o    <= (count_reg == WIDTH'(1));
      busy_o    <= (count_reg != WIDTH'(1));
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule

// [hdl/fmm_flash_map.sv]
`timescale 1ns/1ps
`include "fmm_regs.svh"
// How it works
// - flash is twelve 8 KB erasable blocks
// - chip erase clears the whole array
// - block erase clears one block only
// - reads and programs are byte wide
// - internal timing, byte program 20 us
// - block erase takes about one second
// - flash decodes at 80:0000 to 81:7FFF
// - 4 KB loader region can be disabled
// - boot vector may point anywhere in flash
// - code access low selects external code
// - low 128 bytes direct and indirect
// - upper 128 indirect only, direct is sfr
// - 768 byte xram by external moves only
// - reserved bits written zero, read anything
// - fixed-zero bits always read zero
// - fixed-one bits always read one
// - code access latched at reset release
// - loader enable in aux reg one, A2H
module fmm_flash_map
  import fmm_pkg::*;
#(
  parameter int unsigned BLOCKS       = `FMM_BLK_COUNT,
  parameter int unsigned PROG_NS      = `FMM_PROG_NS,
  parameter int unsigned BLK_ERASE_NS = `FMM_BLK_ERASE_NS,
  parameter int unsigned CHP_ERASE_NS = `FMM_CHIP_ERASE_NS,
  parameter logic [22:0] BOOT_VECTOR  = 23'h000000  // user loader start, offset in flash
) (
  input  wire logic           CLK_I,
  input  wire logic           RESET_I,
  input  wire logic           EXT_CODE_ACCESS_N_I,  // sampled at reset release
  // flash command/read port
  input  wire fmm_flash_req_t FLASH_REQ_I,
  input  wire logic           FLASH_REQ_VALID_I,
  input  wire logic [16:0]    FLASH_RD_ADDR_I,
  output logic [7:0]          FLASH_RD_DATA_O,
  output logic                FLASH_BUSY_O,
  output logic                FLASH_DONE_O,
  output logic                FLASH_REJECT_O,
  // code fetch decode
  input  wire logic [23:0]    CODE_ADDR_I,
  output logic                CODE_INTERNAL_O,
  output logic                CODE_LOADER_O,
  output logic                CODE_EXTERNAL_O,
  output logic [22:0]         BOOT_VECTOR_O,
  // data access decode
  input  wire fmm_dacc_t      DACC_I,
  output fmm_tgt_t            DACC_TGT_O,
  // aux function register one
  input  wire logic           SFR_WR_I,
  input  wire logic [7:0]     SFR_ADDR_I,
  input  wire logic [7:0]     SFR_WDATA_I,
  output logic [7:0]          AUX_FUNCTION_REG_ONE_O
);
  localparam int unsigned TW = 28;
  // cycle counts, rounded to whole cycles (durations are typicals)
  localparam logic [TW-1:0] PROG_CYC  = TW'((PROG_NS + `FMM_CLK_NS - 1) / `FMM_CLK_NS);
  localparam logic [TW-1:0] BLK_CYC   = TW'((BLK_ERASE_NS + `FMM_CLK_NS - 1) / `FMM_CLK_NS);
  localparam logic [TW-1:0] CHP_CYC   = TW'((CHP_ERASE_NS + `FMM_CLK_NS - 1) / `FMM_CLK_NS);
  localparam int unsigned   BLK_BYTES = 1 << `FMM_BLK_BITS;
  localparam int unsigned   BYTES     = BLOCKS * BLK_BYTES;

  initial begin
    if (BLOCKS < 2 || BLOCKS > `FMM_BLK_COUNT) $error("block count out of range");
    if (PROG_NS < `FMM_CLK_NS) $error("program time below one cycle");
  end

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [7:0]  mem [BYTES];          // flash array
  logic        ea_n_reg;             // latched code access level
  logic        rst_d_reg;            // reset seen last cycle
  logic [7:0]  aux1_reg;             // aux function register one
  logic        tmr_start;            // timer load pulse
  logic [TW-1:0] tmr_cycles;         // timer load value
  logic        tmr_busy;             // operation in progress
  logic        tmr_done;             // operation finished
  fmm_flash_req_t op_reg;            // pending operation
  logic        accept;               // command taken this cycle
  logic [$clog2(BYTES)-1:0] wipe_reg; // erase walk index
  logic        wiping_reg;           // erase walk active

  // ----------------------------------------
  // code access strap
  // ----------------------------------------
  // caught on the first clock after release, never under reset
  always_ff @(posedge CLK_I) begin
    rst_d_reg <= RESET_I;
    if (!RESET_I && rst_d_reg) begin
      ea_n_reg <= EXT_CODE_ACCESS_N_I;
    end
  end

  // ----------------------------------------
  // aux function register one
  // ----------------------------------------
  // only the defined bits are kept; fixed-zero bit forced low
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      aux1_reg <= `FMM_AUX1_RESET;
    end else if (SFR_WR_I && SFR_ADDR_I == `FMM_AUX1_ADDR) begin
      aux1_reg <= (SFR_WDATA_I & `FMM_AUX1_WMASK) | `FMM_AUX1_ONE_MASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      AUX_FUNCTION_REG_ONE_O <= `FMM_AUX1_RESET;
    end else begin
      AUX_FUNCTION_REG_ONE_O <= aux1_reg;
    end
  end

  // ----------------------------------------
  // flash command control
  // ----------------------------------------
  // commands during busy or a walk are refused, not queued
  assign accept = FLASH_REQ_VALID_I && !tmr_busy && !wiping_reg && !tmr_start && !tmr_done
                  && FLASH_REQ_I.cmd != FMM_CMD_NONE;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      op_reg         <= '{cmd: FMM_CMD_NONE, addr: '0, data: '0};
      tmr_start      <= 1'b0;
      tmr_cycles     <= '0;
      FLASH_REJECT_O <= 1'b0;
    end else begin
      tmr_start      <= accept;
      FLASH_REJECT_O <= FLASH_REQ_VALID_I && !accept;
      if (accept) begin
        op_reg <= FLASH_REQ_I;
        case (FLASH_REQ_I.cmd)
          FMM_CMD_PROG:       tmr_cycles <= PROG_CYC;
          FMM_CMD_BLK_ERASE:  tmr_cycles <= BLK_CYC;
          FMM_CMD_CHIP_ERASE: tmr_cycles <= CHP_CYC;
          default:            tmr_cycles <= PROG_CYC;
        endcase
      end
    end
  end

  fmm_flash_timer #(.WIDTH(TW)) u_timer (
    .clk_i    (CLK_I),
    .reset_i  (RESET_I),
    .start_i  (tmr_start),
    .cycles_i (tmr_cycles),
    .busy_o   (tmr_busy),
    .done_o   (tmr_done)
  );

  // ----------------------------------------
  // array update at the end of the timed phase
  // ----------------------------------------
  // erase walks one byte per cycle; busy stays up until the walk ends
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wiping_reg <= 1'b0;
      wipe_reg   <= '0;
    end else if (tmr_done) begin
      case (op_reg.cmd)
        FMM_CMD_PROG: begin
          mem[op_reg.addr[$clog2(BYTES)-1:0]] <= op_reg.data;
        end
        FMM_CMD_BLK_ERASE: begin
          wiping_reg <= 1'b1;
          // start at the block base so other blocks stay untouched
          wipe_reg <= {op_reg.addr[$clog2(BYTES)-1:`FMM_BLK_BITS],
                       {`FMM_BLK_BITS{1'b0}}};
        end
        FMM_CMD_CHIP_ERASE: begin
          wiping_reg <= 1'b1;
          wipe_reg   <= '0;
        end
        default: wiping_reg <= 1'b0;
      endcase
    end else if (wiping_reg) begin
      mem[wipe_reg] <= `FMM_ERASED_BYTE;
      wipe_reg <= wipe_reg + 1'b1;
      if (op_reg.cmd == FMM_CMD_BLK_ERASE) begin
        // block end reached when low bits all ones
        wiping_reg <= !(&wipe_reg[`FMM_BLK_BITS-1:0]);
      end else begin
        wiping_reg <= (32'(wipe_reg) != BYTES - 1);
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      FLASH_BUSY_O <= 1'b0;
      FLASH_DONE_O <= 1'b0;
    end else begin
      FLASH_BUSY_O <= accept || tmr_start || tmr_busy || tmr_done || wiping_reg;
      FLASH_DONE_O <= (tmr_done && op_reg.cmd == FMM_CMD_PROG)
                      || (wiping_reg && (op_reg.cmd == FMM_CMD_BLK_ERASE
                          ? &wipe_reg[`FMM_BLK_BITS-1:0]
                          : 32'(wipe_reg) == BYTES - 1));
    end
  end

  // byte-wide read, registered
  always_ff @(posedge CLK_I) begin
    FLASH_RD_DATA_O <= mem[FLASH_RD_ADDR_I[$clog2(BYTES)-1:0]];
  end

  // ----------------------------------------
  // code fetch decode
  // ----------------------------------------
  // loader overlays the flash base while its enable bit is set
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      CODE_INTERNAL_O <= 1'b0;
      CODE_LOADER_O   <= 1'b0;
      CODE_EXTERNAL_O <= 1'b0;
      BOOT_VECTOR_O   <= '0;
    end else begin
      BOOT_VECTOR_O <= BOOT_VECTOR;
      if (ea_n_reg == 1'b0) begin
        // internal memory disabled: full space external
        CODE_INTERNAL_O <= 1'b0;
        CODE_LOADER_O   <= 1'b0;
        CODE_EXTERNAL_O <= 1'b1;
      end else if (aux1_reg[`FMM_AUX1_LDR_BIT]
                   && CODE_ADDR_I >= `FMM_LDR_BASE && CODE_ADDR_I <= `FMM_LDR_LAST) begin
        CODE_INTERNAL_O <= 1'b0;
        CODE_LOADER_O   <= 1'b1;
        CODE_EXTERNAL_O <= 1'b0;
      end else if (CODE_ADDR_I >= `FMM_FLASH_BASE && CODE_ADDR_I <= `FMM_FLASH_LAST) begin
        CODE_INTERNAL_O <= 1'b1;
        CODE_LOADER_O   <= 1'b0;
        CODE_EXTERNAL_O <= 1'b0;
      end else begin
        CODE_INTERNAL_O <= 1'b0;
        CODE_LOADER_O   <= 1'b0;
        CODE_EXTERNAL_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // data access decode
  // ----------------------------------------
  // undefined sfr use is the software's problem, no check here
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      DACC_TGT_O <= FMM_TGT_EXT;
    end else if (DACC_I.xmove) begin
      DACC_TGT_O <= (DACC_I.addr <= `FMM_XRAM_LAST) ? FMM_TGT_XRAM : FMM_TGT_EXT;
    end else if (DACC_I.direct && DACC_I.addr >= `FMM_DATA_BASE
                 && DACC_I.addr <= `FMM_INDIRECT_RAM_LAST) begin
      DACC_TGT_O <= (DACC_I.addr <= `FMM_DATA_LAST) ? FMM_TGT_IRAM : FMM_TGT_SFR;
    end else if (DACC_I.indirect && DACC_I.addr >= `FMM_DATA_BASE
                 && DACC_I.addr <= `FMM_INDIRECT_RAM_LAST) begin
      DACC_TGT_O <= FMM_TGT_IRAM;
    end else if (DACC_I.uptr && DACC_I.addr >= `FMM_DATA_BASE
                 && DACC_I.addr <= `FMM_EXTENDED_RAM_LAST) begin
      DACC_TGT_O <= FMM_TGT_IRAM;
    end else begin
      DACC_TGT_O <= FMM_TGT_EXT;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_busy_refuse: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (FLASH_REQ_VALID_I && tmr_busy) |=> FLASH_REJECT_O)
    else $error("command accepted while busy");
  a_prog_time: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (tmr_start && op_reg.cmd == FMM_CMD_PROG) |-> tmr_cycles == PROG_CYC)
    else $error("program duration wrong");
  a_aux_zero: assert property (@(posedge CLK_I) disable iff (RESET_I)
    aux1_reg[`FMM_AUX1_ZERO_BIT] == 1'b0)
    else $error("fixed-zero bit set");
  a_aux_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (SFR_WR_I && SFR_ADDR_I == `FMM_AUX1_ADDR) |=> ##1
      AUX_FUNCTION_REG_ONE_O[`FMM_AUX1_LDR_BIT] == $past(SFR_WDATA_I[`FMM_AUX1_LDR_BIT], 2))
    else $error("loader enable not stored");
  a_ext_code: assert property (@(posedge CLK_I) disable iff (RESET_I)
    !ea_n_reg |=> CODE_EXTERNAL_O && !CODE_INTERNAL_O && !CODE_LOADER_O)
    else $error("internal fetch with code access low");
  a_ldr_off: assert property (@(posedge CLK_I) disable iff (RESET_I)
    !aux1_reg[`FMM_AUX1_LDR_BIT] |=> !CODE_LOADER_O)
    else $error("loader selected while disabled");
  a_xram_only: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (DACC_TGT_O == FMM_TGT_XRAM) |-> $past(DACC_I.xmove))
    else $error("xram reached without external move");
  a_sfr_direct: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (DACC_I.indirect && !DACC_I.direct && !DACC_I.xmove) |=> DACC_TGT_O != FMM_TGT_SFR)
    else $error("indirect access reached sfr");
  a_done_ends: assert property (@(posedge CLK_I) disable iff (RESET_I)
    FLASH_DONE_O |=> !wiping_reg)
    else $error("done while erase walk continues");
endmodule

// [tb/fmm_core_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// core side model: issues flash commands
// ----------------------------------------
module fmm_core_model
  import fmm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        start_i,  // one-cycle send request
  input  wire fmm_cmd_t    cmd_i,    // command to send
  input  wire logic [16:0] addr_i,   // array offset
  input  wire logic [7:0]  data_i,   // program byte
  output fmm_flash_req_t   req_o,    // request toward the block
  output logic             valid_o   // request qualifier
);
  // quiet request lines at time zero
  initial begin
    req_o   = '{cmd: FMM_CMD_NONE, addr: 17'h0, data: 8'h0};
    valid_o = 1'b0;
  end
  // request shows for one edge only; when idle the lines toggle so a
  // design that samples them outside a request cannot see stale data
  always @(posedge clk_i) begin
    if (start_i) begin
      valid_o <= 1'b1;
      req_o   <= '{cmd: cmd_i, addr: addr_i, data: data_i};
    end else begin
      valid_o <= 1'b0;
      req_o   <= '{cmd: FMM_CMD_NONE, addr: ~req_o.addr, data: ~req_o.data};
    end
  end
endmodule

// [tb/flash_and_memory_map_bench.sv]
`timescale 1ns/1ps
// ----------------------------------------
// bench for flash and memory map
// ----------------------------------------
module flash_and_memory_map_bench
  import fmm_pkg::*;
;
  localparam int PROG_CYC = 100;  // 800 ns at 8 ns per cycle; take to done is this plus 2
  logic CLK_I, RESET_I, EXT_CODE_ACCESS_N_I, FLASH_REQ_VALID_I, SFR_WR_I;
  logic FLASH_BUSY_O, FLASH_DONE_O, FLASH_REJECT_O;
  logic CODE_INTERNAL_O, CODE_LOADER_O, CODE_EXTERNAL_O;
  logic [16:0] FLASH_RD_ADDR_I, m_addr;
  logic [7:0] FLASH_RD_DATA_O, SFR_ADDR_I, SFR_WDATA_I, AUX_FUNCTION_REG_ONE_O, m_data;
  logic [23:0] CODE_ADDR_I;
  logic [22:0] BOOT_VECTOR_O;
  fmm_flash_req_t FLASH_REQ_I;
  fmm_dacc_t DACC_I;
  fmm_tgt_t DACC_TGT_O;
  fmm_cmd_t m_cmd;
  logic m_start;
  int mismatches, num_checks, cyc;
  // ----------------------------------------
  // clock, partner and design
  // ----------------------------------------
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  fmm_core_model i_core (.clk_i(CLK_I), .start_i(m_start), .cmd_i(m_cmd), .addr_i(m_addr),
    .data_i(m_data), .req_o(FLASH_REQ_I), .valid_o(FLASH_REQ_VALID_I));
  // short timed phases and two blocks keep erase walks brief
  fmm_flash_map #(.BLOCKS(2), .PROG_NS(800), .BLK_ERASE_NS(800), .CHP_ERASE_NS(800),
    .BOOT_VECTOR(23'h012345)) i_dut (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .EXT_CODE_ACCESS_N_I(EXT_CODE_ACCESS_N_I),
    .FLASH_REQ_I(FLASH_REQ_I), .FLASH_REQ_VALID_I(FLASH_REQ_VALID_I),
    .FLASH_RD_ADDR_I(FLASH_RD_ADDR_I), .FLASH_RD_DATA_O(FLASH_RD_DATA_O),
    .FLASH_BUSY_O(FLASH_BUSY_O), .FLASH_DONE_O(FLASH_DONE_O),
    .FLASH_REJECT_O(FLASH_REJECT_O), .CODE_ADDR_I(CODE_ADDR_I),
    .CODE_INTERNAL_O(CODE_INTERNAL_O), .CODE_LOADER_O(CODE_LOADER_O),
    .CODE_EXTERNAL_O(CODE_EXTERNAL_O), .BOOT_VECTOR_O(BOOT_VECTOR_O), .DACC_I(DACC_I),
    .DACC_TGT_O(DACC_TGT_O), .SFR_WR_I(SFR_WR_I), .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WDATA_I(SFR_WDATA_I), .AUX_FUNCTION_REG_ONE_O(AUX_FUNCTION_REG_ONE_O));
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard: the whole run needs well under 40000 cycles
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      stop_test();
    end
  end
  // send one command, return cycles from take to done pulse
  task automatic flash_op(input fmm_cmd_t c, input logic [16:0] a, input logic [7:0] d,
                          output int n);
    @(posedge CLK_I);
    m_start <= 1'b1;
    m_cmd <= c;
    m_addr <= a;
    m_data <= d;
    @(posedge CLK_I);
    m_start <= 1'b0;
    @(posedge CLK_I);
    @(posedge CLK_I) #1;
    check(FLASH_BUSY_O, 1'b1);
    n = 1;
    while (FLASH_DONE_O !== 1'b1 && n < 20000) begin
      @(posedge CLK_I) #1;
      n++;
    end
    @(posedge CLK_I) #1;
    check({FLASH_DONE_O, FLASH_BUSY_O}, 2'b00);
  endtask
  task automatic rd(input logic [16:0] a, input logic [7:0] exp);
    @(posedge CLK_I);
    FLASH_RD_ADDR_I <= a;
    repeat (2) @(posedge CLK_I);
    #1 check(FLASH_RD_DATA_O, exp);
  endtask
  task automatic special_function_reg(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge CLK_I);
    SFR_WR_I <= 1'b1;
    SFR_ADDR_I <= a;
    SFR_WDATA_I <= d;
    @(posedge CLK_I);
    SFR_WR_I <= 1'b0;
    repeat (3) @(posedge CLK_I);
    #1 check(AUX_FUNCTION_REG_ONE_O, exp);
  endtask
  task automatic code(input logic [23:0] a, input logic [2:0] exp);
    @(posedge CLK_I);
    CODE_ADDR_I <= a;
    repeat (2) @(posedge CLK_I);
    #1 check({CODE_INTERNAL_O, CODE_LOADER_O, CODE_EXTERNAL_O}, exp);
  endtask
  task automatic dacc(input logic [3:0] k, input logic [23:0] a, input fmm_tgt_t exp);
    @(posedge CLK_I);
    DACC_I <= '{direct: k[3], indirect: k[2], uptr: k[1], xmove: k[0], addr: a};
    repeat (2) @(posedge CLK_I);
    #1 check(DACC_TGT_O, exp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_program();
    int n;
    flash_op(FMM_CMD_PROG, 17'h02001, 8'h5a, n);
    check(24'(n), 24'(PROG_CYC + 2));
    flash_op(FMM_CMD_PROG, 17'h00010, 8'h3c, n);
    rd(17'h02001, 8'h5a);
    rd(17'h00010, 8'h3c);
    $display("test program done");
  endtask
  task automatic t_reject();
    int n;
    fork
      flash_op(FMM_CMD_PROG, 17'h00011, 8'h11, n);
      begin
        repeat (10) @(posedge CLK_I);
        m_start <= 1'b1;  // second command while busy
        m_cmd <= FMM_CMD_CHIP_ERASE;
        @(posedge CLK_I);
        m_start <= 1'b0;
        @(posedge CLK_I) #1;
        check(FLASH_REJECT_O, 1'b1);
      end
    join
    rd(17'h00011, 8'h11);
    rd(17'h02001, 8'h5a);
    $display("test reject done");
  endtask
  task automatic t_erase();
    int n;
    flash_op(FMM_CMD_BLK_ERASE, 17'h00005, 8'h00, n);
    rd(17'h00010, 8'hff);
    rd(17'h02001, 8'h5a);
    flash_op(FMM_CMD_CHIP_ERASE, 17'h00000, 8'h00, n);
    rd(17'h02001, 8'hff);
    rd(17'h03fff, 8'hff);
    $display("test erase done");
  endtask
  task automatic t_maps();
    special_function_reg(8'ha2, 8'h29, 8'h29);
    special_function_reg(8'h8e, 8'h00, 8'h29);
    special_function_reg(8'ha2, 8'h20, 8'h20);
    check(AUX_FUNCTION_REG_ONE_O & 8'h04, 8'h00);
    code(24'h800800, 3'b010);
    code(24'h801000, 3'b100);
    special_function_reg(8'ha2, 8'h00, 8'h00);
    code(24'h800800, 3'b100);
    code(24'h817fff, 3'b100);
    code(24'h818000, 3'b001);
    code(24'h001000, 3'b001);
    @(posedge CLK_I);
    EXT_CODE_ACCESS_N_I <= 1'b0;  // late strap change is ignored
    code(24'h810000, 3'b100);
    check(BOOT_VECTOR_O, 23'h012345);
    dacc(4'b1000, 24'h7f0010, FMM_TGT_IRAM);
    dacc(4'b1000, 24'h7f0080, FMM_TGT_SFR);
    dacc(4'b0100, 24'h7f00ff, FMM_TGT_IRAM);
    dacc(4'b0010, 24'h7f04ff, FMM_TGT_IRAM);
    dacc(4'b0010, 24'h7f0500, FMM_TGT_EXT);
    dacc(4'b0001, 24'h0002ff, FMM_TGT_XRAM);
    dacc(4'b0001, 24'h000300, FMM_TGT_EXT);
    $display("test maps done");
  endtask
  task automatic t_strap();
    special_function_reg(8'ha2, 8'h29, 8'h29);
    @(posedge CLK_I);
    RESET_I <= 1'b1;  // strap pin is still low from the map test
    repeat (3) @(posedge CLK_I);
    RESET_I <= 1'b0;
    #1 check({AUX_FUNCTION_REG_ONE_O, FLASH_BUSY_O, DACC_TGT_O}, 12'h000);
    repeat (2) @(posedge CLK_I);
    code(24'h810000, 3'b001);
    code(24'h800800, 3'b001);
    @(posedge CLK_I);
    EXT_CODE_ACCESS_N_I <= 1'b1;  // late rise must not bring flash back
    code(24'h810000, 3'b001);
    $display("test strap done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    RESET_I = 1'b1;
    EXT_CODE_ACCESS_N_I = 1'b1;
    SFR_WR_I = 1'b0;
    SFR_ADDR_I = 8'h00;
    SFR_WDATA_I = 8'h00;
    FLASH_RD_ADDR_I = 17'h0;
    CODE_ADDR_I = 24'h0;
    DACC_I = '0;
    m_start = 1'b0;
    m_cmd = FMM_CMD_NONE;
    m_addr = 17'h0;
    m_data = 8'h0;
    repeat (3) @(posedge CLK_I);
    RESET_I <= 1'b0;
    #1 check({AUX_FUNCTION_REG_ONE_O, FLASH_BUSY_O}, 9'h000);
    repeat (2) @(posedge CLK_I);
    t_program();
    t_reject();
    t_erase();
    t_maps();
    t_strap();
    stop_test();
  end
endmodule
